// ===== rtl/adcd_clock_chain.sv
// Clock derivation chain, sinc decimator and per-channel calibration.
// Assumes clk_in is the master clock, inputs synchronous to it.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Prescale select 00/01/10/11 divides master clock by 1/2/4/8.
// [R2] Prescale select resets to 00, modulator clock undivided.
// [R3] Sample clock is modulator clock divided by four.
// [R4] One output word every oversampling-ratio sample periods.
// [R5] Each new word is announced by a data-ready pulse.
// [R6] Oversampling select 0..7 gives ratios 32 up to 4096.
// [R7] Oversampling select resets to 011, ratio 256.
// [R8] Decimator is a sinc filter, notches at multiples of output rate.
// [R9] Each channel gets its own 24-bit offset correction.
// [R10] Each channel gets its own 24-bit gain correction.
// [R11] Data ready pulses low half a sample period, unlatched, synchronous.
// [R12] Divider counters cleared in reset, count from zero after release.
module adcd_clock_chain (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // Configuration
  input  wire logic                    cfg_wr_in,
  input  wire logic [1:0]              prescale_sel_in,
  input  wire logic [2:0]              oversample_sel_in,
  output logic      [1:0]              prescale_sel_out,
  output logic      [2:0]              oversample_sel_out,
  // Calibration load
  input  wire logic                    cal_wr_in,
  input  wire logic [2:0]              cal_chan_in,
  input  wire logic [23:0]             chan_offset_corr_in,
  input  wire logic [23:0]             chan_gain_corr_in,
  // Modulator samples, 3-bit signed per channel
  input  wire logic [17:0]             mod_sample_in,
  // Derived clocks and data ready
  output logic                         modulator_clk_out,
  output logic                         sample_clk_out,
  output logic                         output_rate_clk_out,
  output logic                         data_ready_n_out,
  // Corrected results, channel 0 in the low bits
  output logic      [143:0]            result_out,
  output logic                         result_valid_out
);
  logic [1:0]  prescale_q;
  logic [2:0]  osr_q;
  logic [2:0]  pre_cnt_q;
  logic [2:0]  pre_last;
  logic        mod_tick;
  logic [1:0]  quarter_q;
  logic [1:0]  quarter_d;
  logic        samp_tick;
  logic [11:0] osr_cnt_q;
  logic [11:0] osr_last;
  logic        word_tick;
  logic        word_q;
  logic        samp_clk_q;
  logic        dr_n_q;
  logic        dr_cnt_q;
  adcd_pkg::adcd_seq_t seq_q;
  logic [2:0]  rd_ch_q;
  logic        proc_vld_q;
  logic [2:0]  proc_ch_q;
  logic        res_vld_q;
  logic [23:0] cal_off;
  logic [23:0] cal_gain;
  logic [23:0] raw_sel;
  logic [23:0] corr;
  logic [47:0] prod;
  logic [23:0] fixed;
  logic [23:0] raw_q [adcd_pkg::CHANNELS];

  // [R2] [R7] Config defaults at reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_q <= adcd_pkg::PRE_RST;
      osr_q      <= adcd_pkg::OSR_RST;
    end else if (cfg_wr_in) begin
      prescale_q <= prescale_sel_in;
      osr_q      <= oversample_sel_in;
    end
  end

  // [R1] Prescale terminal count
  always_comb begin
    case (prescale_q)
      2'h0:    pre_last = adcd_pkg::PRE_LAST_1;
      2'h1:    pre_last = adcd_pkg::PRE_LAST_2;
      2'h2:    pre_last = adcd_pkg::PRE_LAST_4;
      2'h3:    pre_last = adcd_pkg::PRE_LAST_8;
      default: pre_last = adcd_pkg::PRE_LAST_1;
    endcase
  end

  // [R6] Ratio terminal count
  always_comb begin
    case (osr_q)
      3'h0:    osr_last = adcd_pkg::OSR_LAST_32;
      3'h1:    osr_last = adcd_pkg::OSR_LAST_64;
      3'h2:    osr_last = adcd_pkg::OSR_LAST_128;
      3'h3:    osr_last = adcd_pkg::OSR_LAST_256;
      3'h4:    osr_last = adcd_pkg::OSR_LAST_512;
      3'h5:    osr_last = adcd_pkg::OSR_LAST_1024;
      3'h6:    osr_last = adcd_pkg::OSR_LAST_2048;
      3'h7:    osr_last = adcd_pkg::OSR_LAST_4096;
      default: osr_last = adcd_pkg::OSR_LAST_256;
    endcase
  end

  // Compare with >= so a smaller ratio set mid-count still wraps
  assign mod_tick  = pre_cnt_q >= pre_last;
  assign samp_tick = mod_tick && quarter_q == adcd_pkg::QUARTER_LAST;
  assign word_tick = samp_tick && osr_cnt_q >= osr_last;
  assign quarter_d = mod_tick ? quarter_q + 2'h1 : quarter_q;

  // [R12] [R1] Prescale counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_cnt_q <= 3'h0;
    end else begin
      pre_cnt_q <= mod_tick ? 3'h0 : pre_cnt_q + 3'h1;
    end
  end

  // [R12] [R3] Divide by four into the sample clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quarter_q  <= 2'h0;
      samp_clk_q <= 1'h0;
    end else begin
      quarter_q  <= quarter_d;
      samp_clk_q <= quarter_d < adcd_pkg::QUARTER_HALF;
    end
  end

  // [R12] [R4] Oversampling counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osr_cnt_q <= 12'h000;
    end else if (samp_tick) begin
      osr_cnt_q <= word_tick ? 12'h000 : osr_cnt_q + 12'h001;
    end
  end

  // [R5] [R11] Low for two modulator ticks, then released unlatched
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dr_n_q   <= 1'h1;
      dr_cnt_q <= 1'h0;
      word_q   <= 1'h0;
    end else begin
      word_q <= word_tick;
      if (word_tick) begin
        dr_n_q   <= 1'h0;
        dr_cnt_q <= 1'h0;
      end else if (!dr_n_q && mod_tick) begin
        dr_cnt_q <= 1'h1;
        if (dr_cnt_q == adcd_pkg::DR_LOW_LAST) begin
          dr_n_q <= 1'h1;
        end
      end
    end
  end

  // [R8] Sinc accumulate-and-dump per channel
  for (genvar ch = 0; ch < adcd_pkg::CHANNELS; ch++) begin : g_chan
    logic [23:0] acc_q;
    logic [23:0] sum;
    logic [23:0] res_q;
    assign sum = acc_q + {{21{mod_sample_in[ch*3+2]}},
                          mod_sample_in[ch*3 +: 3]};
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        acc_q     <= 24'h000000;
        raw_q[ch] <= 24'h000000;
      end else if (samp_tick) begin
        acc_q <= word_tick ? 24'h000000 : sum;
        if (word_tick) begin
          raw_q[ch] <= sum;
        end
      end
    end
    // Corrected word lands in its own slice
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        res_q <= 24'h000000;
      end else if (proc_vld_q && proc_ch_q == 3'(ch)) begin
        res_q <= fixed;
      end
    end
    assign result_out[ch*24 +: 24] = res_q;
  end

  // Calibration sequencer walks the channels after each word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_q      <= adcd_pkg::SEQ_IDLE;
      rd_ch_q    <= 3'h0;
      proc_vld_q <= 1'h0;
      proc_ch_q  <= 3'h0;
      res_vld_q  <= 1'h0;
    end else begin
      proc_vld_q <= seq_q == adcd_pkg::SEQ_RUN;
      proc_ch_q  <= rd_ch_q;
      res_vld_q  <= proc_vld_q && proc_ch_q == adcd_pkg::LAST_CH;
      case (seq_q)
        adcd_pkg::SEQ_IDLE: begin
          rd_ch_q <= 3'h0;
          if (word_q) begin
            seq_q <= adcd_pkg::SEQ_RUN;
          end
        end
        adcd_pkg::SEQ_RUN: begin
          rd_ch_q <= rd_ch_q + 3'h1;
          if (rd_ch_q == adcd_pkg::LAST_CH) begin
            seq_q <= adcd_pkg::SEQ_IDLE;
          end
        end
        default: seq_q <= adcd_pkg::SEQ_IDLE;
      endcase
    end
  end

  adcd_cal_mem u_cal_mem (
    .clk_in       (clk_in),
    .wr_in        (cal_wr_in),
    .wr_ch_in     (cal_chan_in),
    .wr_offset_in (chan_offset_corr_in),
    .wr_gain_in   (chan_gain_corr_in),
    .rd_ch_in     (rd_ch_q),
    .rd_offset_out(cal_off),
    .rd_gain_out  (cal_gain)
  );

  // [R9] [R10] Offset add, then slope scaled by one plus gain over 2^23
  // Result wraps on overflow; no saturation, kept small on purpose
  always_comb begin
    raw_sel = raw_q[proc_ch_q < 3'h6 ? proc_ch_q : 3'h0];
    corr    = raw_sel + cal_off;
    prod    = $signed(corr) * $signed(cal_gain);
    fixed   = corr + prod[46:23];
  end

  assign prescale_sel_out    = prescale_q;
  assign oversample_sel_out  = osr_q;
  assign modulator_clk_out   = mod_tick;
  assign sample_clk_out      = samp_clk_q;
  assign output_rate_clk_out = word_q;
  assign data_ready_n_out    = dr_n_q;
  assign result_valid_out    = res_vld_q;

  // Word spacing helper for the rate checks; a config write voids
  // the interval, since the >= compare may then cut it short
  logic [17:0] since_word_q;
  logic        cfg_held_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_word_q <= 18'h00000;
      cfg_held_q   <= 1'h0;
    end else begin
      since_word_q <= word_tick ? 18'h00000 : since_word_q + 18'h00001;
      cfg_held_q   <= !cfg_wr_in && (word_tick || cfg_held_q);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_div8;
    (mod_tick && prescale_q == 2'h3) ##1
      (!mod_tick && prescale_q == 2'h3) [*7];
  endsequence
  property p_div8;
    s_div8 |=> mod_tick || prescale_q != 2'h3;
  endproperty
  a_div8: assert property (p_div8) else $error("div8 period wrong"); // [R1]

  property p_pre_rst;
    !$past(rst_n_in) && !$past(cfg_wr_in) |-> prescale_q == 2'h0;
  endproperty
  a_pre_rst: assert property (p_pre_rst) else $error("prescale rst"); // [R2]

  sequence s_samp_start;
    (samp_tick && prescale_q == 2'h0) ##1 (prescale_q == 2'h0) [*3];
  endsequence
  property p_samp4;
    s_samp_start |-> ##1 samp_tick && !$past(samp_tick, 2);
  endproperty
  a_samp4: assert property (p_samp4) else $error("sample div"); // [R3]

  property p_word128;
    word_tick && cfg_held_q && osr_q == 3'h0 && prescale_q == 2'h0
      |-> since_word_q == 18'h0007F;
  endproperty
  a_word128: assert property (p_word128) else $error("word rate"); // [R4]

  property p_ready;
    word_tick |=> output_rate_clk_out && !data_ready_n_out;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready pulse"); // [R5]

  property p_ratio64;
    word_tick && cfg_held_q && osr_q == 3'h1 && prescale_q == 2'h0
      |-> since_word_q == 18'h000FF;
  endproperty
  a_ratio64: assert property (p_ratio64) else $error("ratio 64"); // [R6]

  property p_osr_rst;
    !$past(rst_n_in) && !$past(cfg_wr_in) |-> osr_q == 3'h3;
  endproperty
  a_osr_rst: assert property (p_osr_rst) else $error("osr rst"); // [R7]

  property p_dump;
    word_tick |=> g_chan[0].acc_q == 24'h000000;
  endproperty
  a_dump: assert property (p_dump) else $error("acc not dumped"); // [R8]

  property p_cal_done;
    output_rate_clk_out |-> ##[8:8] result_valid_out;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("cal late"); // [R9]

  property p_dr_width;
    $fell(data_ready_n_out) && prescale_q == 2'h0
      |-> ##1 !data_ready_n_out ##1 data_ready_n_out;
  endproperty
  a_dr_width: assert property (p_dr_width) else $error("dr width"); // [R11]

  property p_rel;
    !$past(rst_n_in) |-> osr_cnt_q == 12'h000 && data_ready_n_out;
  endproperty
  a_rel: assert property (p_rel) else $error("counter not clear"); // [R12]
endmodule

// ===== rtl/adcd_pkg.sv
// Constants and types for the converter clock chain and calibration.
// Assumes one master clock domain and an active-low asynchronous reset.
package adcd_pkg;
  // Channel and word geometry
  localparam int CHANNELS   = 6;
  localparam int CH_W       = 3;
  localparam int WORD_W     = 24;
  localparam int SAMPLE_W   = 3;
  localparam int GAIN_FRAC  = 23;
  localparam int OSR_CNT_W  = 12;
  // Configuration fields and reset values
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [2:0] OSR_RST = 3'h3;
  // Prescaler terminal counts, divide by 1, 2, 4 and 8
  localparam logic [2:0] PRE_LAST_1 = 3'h0;
  localparam logic [2:0] PRE_LAST_2 = 3'h1;
  localparam logic [2:0] PRE_LAST_4 = 3'h3;
  localparam logic [2:0] PRE_LAST_8 = 3'h7;
  // Modulator ticks per sample, and ticks data ready stays low
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] QUARTER_HALF = 2'h2;
  localparam logic       DR_LOW_LAST  = 1'h1;
  // Oversampling terminal counts, ratio minus one
  localparam logic [11:0] OSR_LAST_32   = 12'h01F;
  localparam logic [11:0] OSR_LAST_64   = 12'h03F;
  localparam logic [11:0] OSR_LAST_128  = 12'h07F;
  localparam logic [11:0] OSR_LAST_256  = 12'h0FF;
  localparam logic [11:0] OSR_LAST_512  = 12'h1FF;
  localparam logic [11:0] OSR_LAST_1024 = 12'h3FF;
  localparam logic [11:0] OSR_LAST_2048 = 12'h7FF;
  localparam logic [11:0] OSR_LAST_4096 = 12'hFFF;
  localparam logic [2:0]  LAST_CH       = 3'h5;
  // Calibration sequencer states
  typedef enum logic {SEQ_IDLE, SEQ_RUN} adcd_seq_t;
endpackage

// ===== rtl/adcd_cal_mem.sv
// Per-channel offset and gain calibration store.
// Assumes one writer and one reader; read data appear one cycle later.
`timescale 1ns/1ps
module adcd_cal_mem (
  // Clock
  input  wire logic                       clk_in,
  // Write side
  input  wire logic                       wr_in,
  input  wire logic [adcd_pkg::CH_W-1:0]   wr_ch_in,
  input  wire logic [adcd_pkg::WORD_W-1:0] wr_offset_in,
  input  wire logic [adcd_pkg::WORD_W-1:0] wr_gain_in,
  // Read side
  input  wire logic [adcd_pkg::CH_W-1:0]   rd_ch_in,
  output logic      [adcd_pkg::WORD_W-1:0] rd_offset_out,
  output logic      [adcd_pkg::WORD_W-1:0] rd_gain_out
);
  logic [adcd_pkg::WORD_W-1:0] offset_mem [adcd_pkg::CHANNELS];
  logic [adcd_pkg::WORD_W-1:0] gain_mem   [adcd_pkg::CHANNELS];

  // Storage holds no reset, like a plain RAM; software loads it
  always_ff @(posedge clk_in) begin
    if (wr_in && wr_ch_in <= adcd_pkg::LAST_CH) begin
      offset_mem[wr_ch_in] <= wr_offset_in;
      gain_mem[wr_ch_in]   <= wr_gain_in;
    end
  end

  // Registered read
  always_ff @(posedge clk_in) begin
    rd_offset_out <= offset_mem[rd_ch_in];
    rd_gain_out   <= gain_mem[rd_ch_in];
  end
endmodule

// ===== verif/adcd_mclk_src.sv
// Master clock source model for the clock chain bench.
// Assumes a free-running oscillator that never stops or jitters.
`timescale 1ns/1ps
module adcd_mclk_src (
  // Master clock
  output logic clk_out
);
  // Free running, 10 ns period; the chain needs it even in reset
  initial begin
    clk_out = 1'b0;
    forever #5 clk_out = ~clk_out;
  end
endmodule

// ===== verif/adcd_clock_chain_tb_top.sv
// Self-checking bench for the clock chain, data ready and calibration.
// Assumes the clock source model and inputs driven at the rising edge.
`timescale 1ns/1ps
module adcd_clock_chain_tb_top;
  logic         clk_in;
  logic         rst_n_in;
  logic         cfg_wr_in;
  logic [1:0]   prescale_sel_in;
  logic [2:0]   oversample_sel_in;
  logic [1:0]   prescale_sel_out;
  logic [2:0]   oversample_sel_out;
  logic         cal_wr_in;
  logic [2:0]   cal_chan_in;
  logic [23:0]  chan_offset_corr_in;
  logic [23:0]  chan_gain_corr_in;
  logic [17:0]  mod_sample_in;
  logic         modulator_clk_out;
  logic         sample_clk_out;
  logic         output_rate_clk_out;
  logic         data_ready_n_out;
  logic [143:0] result_out;
  logic         result_valid_out;
  logic [31:0]  seed;
  int           fail_count;
  int           n_checks;
  int           cycles;

  adcd_mclk_src u_src (.clk_out(clk_in));

  adcd_clock_chain dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr_in),
    .prescale_sel_in(prescale_sel_in),
    .oversample_sel_in(oversample_sel_in),
    .prescale_sel_out(prescale_sel_out),
    .oversample_sel_out(oversample_sel_out),
    .cal_wr_in(cal_wr_in), .cal_chan_in(cal_chan_in),
    .chan_offset_corr_in(chan_offset_corr_in),
    .chan_gain_corr_in(chan_gain_corr_in),
    .mod_sample_in(mod_sample_in),
    .modulator_clk_out(modulator_clk_out),
    .sample_clk_out(sample_clk_out),
    .output_rate_clk_out(output_rate_clk_out),
    .data_ready_n_out(data_ready_n_out),
    .result_out(result_out), .result_valid_out(result_valid_out)
  );

  // Pseudo-random source, fixed start for repeatable runs
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded waits on the word pulse and the result strobe
  task automatic wait_word();
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (output_rate_clk_out !== 1'b1 && k < 20000);
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (result_valid_out !== 1'b1 && k < 20000);
  endtask

  // Both selects go in one write, as the port pairs them
  task automatic cfg(input logic [1:0] pre, input logic [2:0] osr);
    @(posedge clk_in);
    cfg_wr_in         <= 1'b1;
    prescale_sel_in   <= pre;
    oversample_sel_in <= osr;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    #1;
    check(prescale_sel_out, pre);
    check(oversample_sel_out, osr);
  endtask

  // One whole word period; the first period after a change may be short
  task automatic measure(input int pre, input int osr);
    int   per, mt, sr, dl, p, r;
    logic sc;
    p   = 1 << pre;
    r   = 32 << osr;
    per = 0;
    mt  = 0;
    sr  = 0;
    dl  = 0;
    wait_word();
    check(data_ready_n_out, 1'b0);
    do begin
      per++;
      mt += int'(modulator_clk_out === 1'b1);
      dl += int'(data_ready_n_out === 1'b0);
      sc = sample_clk_out;
      @(posedge clk_in);
      #1;
      // Rises counted per edge crossed, closing edge included
      sr += int'(sample_clk_out === 1'b1 && sc === 1'b0);
    end while (output_rate_clk_out !== 1'b1 && per < 20000);
    check(per, 4 * p * r);
    check(mt, 4 * r);
    check(sr, r);
    check(dl, 2 * p);
  endtask

  // Random calibration and constant samples; the mixed word is skipped
  task automatic cal_round();
    logic [23:0] off [7];
    logic [23:0] gn [7];
    logic [2:0]  s [7];
    logic [23:0] co;
    logic [23:0] ex;
    longint      m;
    wait_valid();
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      off[i] = seed[23:0];
      seed = lfsr(seed);
      gn[i] = seed[23:0];
      s[i] = seed[26:24];
      @(posedge clk_in);
      cal_wr_in           <= 1'b1;
      cal_chan_in         <= 3'(i == 6 ? 6 : i);
      chan_offset_corr_in <= off[i];
      chan_gain_corr_in   <= gn[i];
      if (i < 6) begin
        mod_sample_in[3 * i +: 3] <= s[i];
      end
    end
    @(posedge clk_in);
    cal_wr_in <= 1'b0;
    wait_valid();
    wait_valid();
    for (int i = 0; i < 6; i++) begin
      co = 24'(32 * longint'($signed(s[i]))) + off[i];
      m  = longint'($signed(co)) * longint'($signed(gn[i]));
      ex = co + m[46:23];
      check(result_out[24 * i +: 24], ex);
    end
  endtask

  // Run limit, about a quarter above the expected length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    seed                = 32'hBE20;
    fail_count          = 0;
    n_checks            = 0;
    cycles              = 0;
    rst_n_in            = 1'b0;
    cfg_wr_in           = 1'b0;
    prescale_sel_in     = 2'h0;
    oversample_sel_in   = 3'h0;
    cal_wr_in           = 1'b0;
    cal_chan_in         = 3'h0;
    chan_offset_corr_in = 24'h000000;
    chan_gain_corr_in   = 24'h000000;
    mod_sample_in       = 18'h00000;
    repeat (5) @(posedge clk_in);
    #1;
    check(prescale_sel_out, 2'h0);
    check(oversample_sel_out, 3'h3);
    check({data_ready_n_out, output_rate_clk_out}, 2'h2);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    measure(0, 3);
    for (int p = 0; p < 4; p++) begin
      cfg(2'(p), 3'h0);
      measure(p, 0);
    end
    for (int o = 0; o < 8; o++) begin
      cfg(2'h0, 3'(o));
      measure(0, o);
    end
    cfg(2'h0, 3'h0);
    repeat (4) cal_round();
    // Second reset in mid-run must restore defaults
    cfg(2'h2, 3'h5);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    #1;
    check(prescale_sel_out, 2'h0);
    check(oversample_sel_out, 3'h3);
    check(data_ready_n_out, 1'b1);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    measure(0, 3);
    conclude();
  end
endmodule
